// ---- core/css_consts.vh ----
// Constants for the charger safety supervisor
`ifndef CSS_CONSTS_VH
`define CSS_CONSTS_VH
// Clock and timebase
`define CSS_CLK_NS 4
`define CSS_TICK_NS 1000000
`define CSS_DBC_TICKS 16'h0020
// Charger states
`define CSS_ST_IDLE 4'h0
`define CSS_ST_PRECHG 4'h1
`define CSS_ST_TRICKLE 4'h2
`define CSS_ST_FC_CC 4'h3
`define CSS_ST_FC_CV 4'h4
`define CSS_ST_TOPOFF 4'h5
`define CSS_ST_DONE 4'h6
`define CSS_ST_TMR_FAULT 4'h7
`define CSS_ST_WD_SUSP 4'h8
`define CSS_ST_THM_SHDN 4'h9
`define CSS_ST_TEMP_SUSP 4'hA
// Detail codes
`define CSS_DTL_TRICKLE 4'h0
`define CSS_DTL_FC_CC 4'h1
`define CSS_DTL_FC_CV 4'h2
`define CSS_DTL_TOPOFF 4'h3
`define CSS_DTL_DONE 4'h4
`define CSS_DTL_OK_MAX 4'h4
`define CSS_DTL_PRECHG 4'h5
`define CSS_DTL_TMR_FAULT 4'h6
`define CSS_DTL_OFF 4'h8
`define CSS_DTL_THM_SHDN 4'hA
`define CSS_DTL_WD_EXP 4'hB
`define CSS_DTL_TEMP_SUSP 4'hC
// Timer groups
`define CSS_GRP_NONE 2'h0
`define CSS_GRP_PREQ 2'h1
`define CSS_GRP_FAST 2'h2
`define CSS_GRP_TOPOFF 2'h3
// Thermistor zone codes
`define CSS_ZN_COLD 3'h0
`define CSS_ZN_COOL 3'h1
`define CSS_ZN_NORMAL 3'h2
`define CSS_ZN_WARM 3'h3
`define CSS_ZN_HOT 3'h4
`define CSS_ZN_DISABLED 3'h5
// Current select codes
`define CSS_CUR_PRECHG 2'h0
`define CSS_CUR_TRICKLE 2'h1
`define CSS_CUR_FAST 2'h2
// Mode field and host keys
`define CSS_MODE_DEFAULT 4'h5
`define CSS_MODE_CHG_ON 4'h5
`define CSS_WDCLR_KEY 2'h1
`define CSS_OFFSET_OFF 2'h0
`define CSS_OVC_OFF 4'h0
// Warm zone drop in voltage setting steps
`define CSS_CV_WARM_DROP 8'h0C
// Loop offset per code step, 0.1 mV and 0.1 mA units
`define CSS_CVOFS_2S 11'd229
`define CSS_CVOFS_3S 11'd344
`define CSS_CCOFS_STEP 11'd625
`endif

// ---- core/css_tick_div.v ----
// Slow timebase divider producing a one-cycle tick
`timescale 1ns/1ns
module css_tick_div #(
  parameter DIV = 250000
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Tick out
  output reg tick
);
  reg [31:0] cnt_ff;

  // Free-running count, pulse on wrap
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff <= 32'h00000000;
      tick <= 1'b0;
    end
    else if (cnt_ff >= DIV - 1)
    begin
      cnt_ff <= 32'h00000000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule

// ---- core/css_sync.v ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module css_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Pins in, filtered levels out
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  genvar i;

  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      // First stage feeds only the second; level taken when 2 and 3 agree
      always @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          s1_ff[i] <= 1'b0;
          s2_ff[i] <= 1'b0;
          s3_ff[i] <= 1'b0;
          dout[i] <= 1'b0;
        end
        else
        begin
          s1_ff[i] <= din[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (s2_ff[i] == s3_ff[i])
            dout[i] <= s3_ff[i];
        end
      end
    end
  endgenerate
endmodule

// ---- core/css_supervisor.v ----
// Charger safety supervisor: state machine, timers, zones, ship mode
`timescale 1ns/1ns
`include "css_consts.vh"
module css_supervisor #(
  parameter TICK_CYCLES = `CSS_TICK_NS / `CSS_CLK_NS
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire RESETN,
  // Analog comparator and pin inputs, asynchronous
  input wire INPUT_VALID,
  input wire BATTERY_DISCONNECT_PIN,
  input wire STANDBY_PIN,
  input wire DIE_OVER_SHDN,
  input wire DIE_OVER_REG,
  input wire BATT_COLD,
  input wire BATT_COOL,
  input wire BATT_WARM,
  input wire BATT_HOT,
  input wire VBAT_ABOVE_PRECHG,
  input wire VBAT_ABOVE_SYSMIN,
  input wire VBAT_AT_REG,
  input wire ICHG_BELOW_TOPOFF,
  input wire VBAT_BELOW_RESTART,
  // Host writes and reads
  input wire MODE_WR,
  input wire [3:0] MODE_WDATA,
  input wire WD_EN_WR,
  input wire WD_EN_WDATA,
  input wire WD_CLR_WR,
  input wire [1:0] WD_CLR_WDATA,
  input wire IRQ_READ,
  // Host settings
  input wire [15:0] PREQUAL_TIME_LIMIT,
  input wire [15:0] FAST_CHARGE_TIME_LIMIT,
  input wire [15:0] TOPOFF_DURATION,
  input wire [15:0] WATCHDOG_PERIOD,
  input wire TEMP_ZONE_CONTROL_ENABLE,
  input wire [7:0] FAST_CHARGE_CURRENT_SETTING,
  input wire [7:0] COOL_CURRENT_SETTING,
  input wire [7:0] TERMINATION_VOLTAGE_SETTING,
  input wire [7:0] COOL_VOLTAGE_SETTING,
  input wire [1:0] VOLTAGE_LOOP_OFFSET,
  input wire [1:0] CURRENT_LOOP_OFFSET,
  input wire CELLS_3S,
  input wire SHIP_MODE_BIT,
  input wire [3:0] BATTERY_OVERCURRENT_THRESHOLD,
  // Status to host
  output reg CHARGER_IRQ,
  output reg CHARGER_OK_STATUS,
  output reg [3:0] CHARGER_DETAIL_FIELD,
  output reg THERMAL_REGULATION_STATUS,
  output reg [2:0] THERMISTOR_DETAIL_FIELD,
  output reg [3:0] MODE_FIELD,
  output reg WATCHDOG_ENABLE_BIT,
  // Controls to power stage
  output reg CHARGE_ENABLE,
  output reg CONVERTER_ENABLE,
  output reg [1:0] CURRENT_SELECT,
  output reg [7:0] APPLIED_CURRENT,
  output reg [7:0] APPLIED_VOLTAGE,
  output reg TIMER_DOUBLED,
  output reg [10:0] CV_TRANSITION_OFFSET,
  output reg [10:0] CC_TRANSITION_OFFSET,
  output reg SHIP_MODE,
  output reg SERIAL_IF_ENABLE,
  output reg OVERCURRENT_MONITOR_EN,
  output reg [3:0] OVERCURRENT_THRESHOLD_OUT
);
  wire tick;
  wire [13:0] pins_q;
  wire in_ok = pins_q[0];
  wire disq = pins_q[1];
  wire standby_pin = pins_q[2];
  wire shdn = pins_q[3];
  wire thermal_regulation_status = pins_q[4];
  wire z_cold = pins_q[5];
  wire z_cool = pins_q[6];
  wire z_warm = pins_q[7];
  wire z_hot = pins_q[8];
  wire above_pre = pins_q[9];
  wire above_sys = pins_q[10];
  wire at_reg = pins_q[11];
  wire below_to = pins_q[12];
  wire restart = pins_q[13];

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [16:0] sc_cnt_ff;
  reg [15:0] wd_cnt_ff;
  reg [15:0] dbc_ff;
  reg in_ok_d_ff;
  reg thermal_regulation_status_d_ff;
  reg mode_off_seen_ff;
  reg disq_hi_seen_ff;
  reg [2:0] zone;
  reg [16:0] lim_eff;
  reg [3:0] nxt_detail;
  reg nxt_irq_evt;

  // Timebase for all safety timers and the watchdog
  css_tick_div #(.DIV(TICK_CYCLES)) u_tick (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .tick(tick)
  );

  // Every pin passes the agreement synchroniser
  css_sync #(.W(14)) u_sync (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .din({VBAT_BELOW_RESTART, ICHG_BELOW_TOPOFF, VBAT_AT_REG,
      VBAT_ABOVE_SYSMIN, VBAT_ABOVE_PRECHG, BATT_HOT, BATT_WARM,
      BATT_COOL, BATT_COLD, DIE_OVER_REG, DIE_OVER_SHDN, STANDBY_PIN,
      BATTERY_DISCONNECT_PIN, INPUT_VALID}),
    .dout(pins_q)
  );

  // First charging state picked from battery voltage
  function [3:0] entry_state;
    input pre;
    input sys;
    begin
      if (!pre)
        entry_state = `CSS_ST_PRECHG;
      else if (!sys)
        entry_state = `CSS_ST_TRICKLE;
      else
        entry_state = `CSS_ST_FC_CC;
    end
  endfunction

  // Which safety timer a state belongs to
  function [1:0] tmr_group;
    input [3:0] st;
    begin
      case (st)
        `CSS_ST_PRECHG, `CSS_ST_TRICKLE: tmr_group = `CSS_GRP_PREQ;
        `CSS_ST_FC_CC, `CSS_ST_FC_CV: tmr_group = `CSS_GRP_FAST;
        `CSS_ST_TOPOFF: tmr_group = `CSS_GRP_TOPOFF;
        default: tmr_group = `CSS_GRP_NONE;
      endcase
    end
  endfunction

  // Writes are ignored while the serial interface is down
  wire host_ok = !SHIP_MODE;
  wire wd_clr_hit = host_ok && WD_CLR_WR &&
    (WD_CLR_WDATA == `CSS_WDCLR_KEY);
  wire chg_on = (MODE_FIELD == `CSS_MODE_CHG_ON);
  wire allowed = chg_on && in_ok && !SHIP_MODE;
  wire wd_exp = WATCHDOG_ENABLE_BIT &&
    (wd_cnt_ff >= WATCHDOG_PERIOD);
  wire zone_stop = TEMP_ZONE_CONTROL_ENABLE &&
    (z_cold || z_hot);
  wire halved = ({APPLIED_CURRENT, 1'b0} <=
    {1'b0, FAST_CHARGE_CURRENT_SETTING});
  wire [1:0] grp = tmr_group(state_ff);
  wire tmr_exp = (grp != `CSS_GRP_NONE) && (sc_cnt_ff >= lim_eff);

  // Timer limit per group, doubled when current is halved, except in the top-off group
  always @*
  begin
    case (grp)
      `CSS_GRP_PREQ: lim_eff = {1'b0, PREQUAL_TIME_LIMIT};
      `CSS_GRP_FAST: lim_eff = {1'b0, FAST_CHARGE_TIME_LIMIT};
      `CSS_GRP_TOPOFF: lim_eff = {1'b0, TOPOFF_DURATION};
      default: lim_eff = {1'b0, 16'hFFFF};
    endcase
    if (halved && grp != `CSS_GRP_TOPOFF)
      lim_eff = {lim_eff[15:0], 1'b0};
  end

  // Battery temperature zone
  always @*
  begin
    if (!TEMP_ZONE_CONTROL_ENABLE)
      zone = `CSS_ZN_DISABLED;
    else if (z_cold)
      zone = `CSS_ZN_COLD;
    else if (z_hot)
      zone = `CSS_ZN_HOT;
    else if (z_cool)
      zone = `CSS_ZN_COOL;
    else if (z_warm)
      zone = `CSS_ZN_WARM;
    else
      zone = `CSS_ZN_NORMAL;
  end

  // Charger state machine; replug and shutdown act from any state
  always @*
  begin
    nxt_state = state_ff;
    if (!in_ok && in_ok_d_ff)
      nxt_state = `CSS_ST_IDLE;
    else if (shdn)
      nxt_state = `CSS_ST_THM_SHDN;
    else
      case (state_ff)
        `CSS_ST_IDLE:
          if (allowed && !zone_stop)
            nxt_state = entry_state(above_pre, above_sys);
        `CSS_ST_TMR_FAULT:
          if ((chg_on && mode_off_seen_ff) || (!disq && disq_hi_seen_ff))
            nxt_state = `CSS_ST_IDLE;
        `CSS_ST_WD_SUSP:
          if (wd_clr_hit)
            nxt_state = `CSS_ST_IDLE;
        `CSS_ST_THM_SHDN:
          nxt_state = `CSS_ST_IDLE;
        `CSS_ST_TEMP_SUSP:
          if (!zone_stop)
            nxt_state = `CSS_ST_IDLE;
        default:
          if (!allowed)
            nxt_state = `CSS_ST_IDLE;
          else if (zone_stop)
            nxt_state = `CSS_ST_TEMP_SUSP;
          else if (wd_exp && state_ff != `CSS_ST_PRECHG)
            nxt_state = `CSS_ST_WD_SUSP;
          else if (tmr_exp && grp != `CSS_GRP_TOPOFF)
            nxt_state = `CSS_ST_TMR_FAULT;
          else
            case (state_ff)
              `CSS_ST_PRECHG:
                if (above_pre)
                  nxt_state = `CSS_ST_TRICKLE;
              `CSS_ST_TRICKLE:
                if (above_sys)
                  nxt_state = `CSS_ST_FC_CC;
              `CSS_ST_FC_CC:
                if (at_reg)
                  nxt_state = `CSS_ST_FC_CV;
              `CSS_ST_FC_CV:
                if (below_to)
                  nxt_state = `CSS_ST_TOPOFF;
              `CSS_ST_TOPOFF:
                if (restart)
                  nxt_state = `CSS_ST_FC_CC;
                else if (tmr_exp)
                  nxt_state = `CSS_ST_DONE;
              `CSS_ST_DONE:
                if (restart)
                  nxt_state = `CSS_ST_FC_CC;
              default:
                nxt_state = `CSS_ST_IDLE;
            endcase
      endcase
  end

  // Detail update: faults at once, charging codes after debounce
  always @*
  begin
    nxt_detail = CHARGER_DETAIL_FIELD;
    nxt_irq_evt = 1'b0;
    case (state_ff)
      `CSS_ST_TMR_FAULT:
      begin
        nxt_detail = `CSS_DTL_TMR_FAULT;
        nxt_irq_evt = (CHARGER_DETAIL_FIELD != `CSS_DTL_TMR_FAULT);
      end
      `CSS_ST_WD_SUSP: nxt_detail = `CSS_DTL_WD_EXP;
      `CSS_ST_THM_SHDN: nxt_detail = `CSS_DTL_THM_SHDN;
      `CSS_ST_TEMP_SUSP: nxt_detail = `CSS_DTL_TEMP_SUSP;
      `CSS_ST_IDLE: nxt_detail = `CSS_DTL_OFF;
      default:
        if (dbc_ff >= `CSS_DBC_TICKS)
          case (state_ff)
            `CSS_ST_TRICKLE: nxt_detail = `CSS_DTL_TRICKLE;
            `CSS_ST_FC_CC: nxt_detail = `CSS_DTL_FC_CC;
            `CSS_ST_FC_CV: nxt_detail = `CSS_DTL_FC_CV;
            `CSS_ST_TOPOFF: nxt_detail = `CSS_DTL_TOPOFF;
            `CSS_ST_DONE: nxt_detail = `CSS_DTL_DONE;
            default: nxt_detail = `CSS_DTL_PRECHG;
          endcase
    endcase
    // Ok rises or falls: irq on either edge of ok
    if ((nxt_detail <= `CSS_DTL_OK_MAX) != CHARGER_OK_STATUS)
      nxt_irq_evt = 1'b1;
    if (thermal_regulation_status != thermal_regulation_status_d_ff)
      nxt_irq_evt = 1'b1;
  end

  // State, timers and held configuration
  always @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_ff <= `CSS_ST_IDLE;
      sc_cnt_ff <= 17'h00000;
      wd_cnt_ff <= 16'h0000;
      dbc_ff <= 16'h0000;
      in_ok_d_ff <= 1'b0;
      thermal_regulation_status_d_ff <= 1'b0;
      mode_off_seen_ff <= 1'b0;
      disq_hi_seen_ff <= 1'b0;
      MODE_FIELD <= `CSS_MODE_DEFAULT;
      WATCHDOG_ENABLE_BIT <= 1'b0;
      CHARGER_IRQ <= 1'b0;
      CHARGER_OK_STATUS <= 1'b0;
      CHARGER_DETAIL_FIELD <= `CSS_DTL_OFF;
      THERMAL_REGULATION_STATUS <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      in_ok_d_ff <= in_ok;
      thermal_regulation_status_d_ff <= thermal_regulation_status;
      THERMAL_REGULATION_STATUS <= thermal_regulation_status;
      // Safety timer restarts when the timer group changes
      if (tmr_group(nxt_state) != grp)
        sc_cnt_ff <= 17'h00000;
      else if (tick && sc_cnt_ff != 17'h1FFFF)
        sc_cnt_ff <= sc_cnt_ff + 17'h00001;
      if (nxt_state != state_ff)
        dbc_ff <= 16'h0000;
      else if (tick && dbc_ff != 16'hFFFF)
        dbc_ff <= dbc_ff + 16'h0001;
      // Watchdog count restarts on a valid clear
      if (wd_clr_hit || !WATCHDOG_ENABLE_BIT)
        wd_cnt_ff <= 16'h0000;
      else if (tick && wd_cnt_ff != 16'hFFFF)
        wd_cnt_ff <= wd_cnt_ff + 16'h0001;
      // Fault exit tracking, cleared outside the fault
      if (state_ff != `CSS_ST_TMR_FAULT)
      begin
        mode_off_seen_ff <= 1'b0;
        disq_hi_seen_ff <= 1'b0;
      end
      else
      begin
        if (!chg_on)
          mode_off_seen_ff <= 1'b1;
        if (disq)
          disq_hi_seen_ff <= 1'b1;
      end
      // Shutdown returns held config to default
      if (state_ff == `CSS_ST_THM_SHDN)
      begin
        MODE_FIELD <= `CSS_MODE_DEFAULT;
        WATCHDOG_ENABLE_BIT <= 1'b0;
      end
      else
      begin
        if (host_ok && MODE_WR)
          MODE_FIELD <= MODE_WDATA;
        if (host_ok && WD_EN_WR)
          WATCHDOG_ENABLE_BIT <= WD_EN_WDATA;
      end
      CHARGER_DETAIL_FIELD <= nxt_detail;
      CHARGER_OK_STATUS <= (nxt_detail <= `CSS_DTL_OK_MAX);
      // Set wins over the read clear so no event is lost
      if (nxt_irq_evt)
        CHARGER_IRQ <= 1'b1;
      else if (host_ok && IRQ_READ)
        CHARGER_IRQ <= 1'b0;
    end
  end

  // Power stage controls and zone adjustments
  always @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      CHARGE_ENABLE <= 1'b0;
      CONVERTER_ENABLE <= 1'b0;
      CURRENT_SELECT <= `CSS_CUR_PRECHG;
      APPLIED_CURRENT <= 8'h00;
      APPLIED_VOLTAGE <= 8'h00;
      TIMER_DOUBLED <= 1'b0;
      CV_TRANSITION_OFFSET <= 11'h000;
      CC_TRANSITION_OFFSET <= 11'h000;
      THERMISTOR_DETAIL_FIELD <= `CSS_ZN_DISABLED;
      SHIP_MODE <= 1'b0;
      SERIAL_IF_ENABLE <= 1'b1;
      OVERCURRENT_MONITOR_EN <= 1'b0;
      OVERCURRENT_THRESHOLD_OUT <= `CSS_OVC_OFF;
    end
    else
    begin
      // Converter keeps supplying the system in watchdog suspend
      CHARGE_ENABLE <= (tmr_group(state_ff) != `CSS_GRP_NONE) ||
        (state_ff == `CSS_ST_DONE);
      CONVERTER_ENABLE <= !SHIP_MODE &&
        (state_ff != `CSS_ST_THM_SHDN);
      if (!above_pre)
        CURRENT_SELECT <= `CSS_CUR_PRECHG;
      else if (!above_sys)
        CURRENT_SELECT <= `CSS_CUR_TRICKLE;
      else
        CURRENT_SELECT <= `CSS_CUR_FAST;
      THERMISTOR_DETAIL_FIELD <= zone;
      if (zone == `CSS_ZN_COOL)
      begin
        APPLIED_CURRENT <= COOL_CURRENT_SETTING;
        APPLIED_VOLTAGE <= COOL_VOLTAGE_SETTING;
      end
      else
      begin
        APPLIED_CURRENT <= FAST_CHARGE_CURRENT_SETTING;
        if (zone != `CSS_ZN_WARM)
          APPLIED_VOLTAGE <= TERMINATION_VOLTAGE_SETTING;
        else if (TERMINATION_VOLTAGE_SETTING > `CSS_CV_WARM_DROP)
          APPLIED_VOLTAGE <= TERMINATION_VOLTAGE_SETTING -
            `CSS_CV_WARM_DROP;
        else
          APPLIED_VOLTAGE <= 8'h00;
      end
      TIMER_DOUBLED <= halved && (grp != `CSS_GRP_NONE);
      // Offset moves the entry point only; regulation stays exact
      if (VOLTAGE_LOOP_OFFSET == `CSS_OFFSET_OFF ||
        state_ff == `CSS_ST_FC_CV || state_ff == `CSS_ST_TOPOFF)
        CV_TRANSITION_OFFSET <= 11'h000;
      else
        CV_TRANSITION_OFFSET <= (CELLS_3S ? `CSS_CVOFS_3S :
          `CSS_CVOFS_2S) * {9'h000, VOLTAGE_LOOP_OFFSET};
      if (CURRENT_LOOP_OFFSET == `CSS_OFFSET_OFF ||
        state_ff == `CSS_ST_FC_CC)
        CC_TRANSITION_OFFSET <= 11'h000;
      else
        CC_TRANSITION_OFFSET <= `CSS_CCOFS_STEP *
          {9'h000, CURRENT_LOOP_OFFSET};
      // Exit wins over entry when both hold
      if (in_ok || standby_pin)
        SHIP_MODE <= 1'b0;
      else if (disq || SHIP_MODE_BIT)
        SHIP_MODE <= 1'b1;
      SERIAL_IF_ENABLE <= !(SHIP_MODE && !(in_ok || standby_pin));
      OVERCURRENT_MONITOR_EN <=
        (BATTERY_OVERCURRENT_THRESHOLD != `CSS_OVC_OFF);
      OVERCURRENT_THRESHOLD_OUT <= BATTERY_OVERCURRENT_THRESHOLD;
    end
  end
endmodule

// ---- dv/css_host_model.sv ----
// Host model that services the watchdog clear field
`timescale 1ns/1ns
module css_host_model #(
  parameter GAP = 40
) (
  // Clock
  input wire clk,
  // Service control from the bench
  input wire svc,
  input wire bad_key,
  // Clear write strobe and data
  output logic wr = 1'b0,
  output logic [1:0] wdata = 2'h0
);
  int cnt = 0;
  // Clears well inside the period; a bad key must be refused
  // Data wanders between strobes so a stale key never passes
  always @(posedge clk)
  begin
    cnt <= (cnt == GAP) ? 0 : cnt + 1;
    wr <= #1 svc && (cnt == GAP);
    wdata <= #1 (cnt == GAP) ? (bad_key ? 2'h2 : 2'h1) : cnt[1:0];
  end
endmodule

// ---- dv/css_supervisor_monitor.sv ----
// Port assertions for the charger safety supervisor
`timescale 1ns/1ns
module css_supervisor_monitor (
  // Clock and reset
  input wire CLK_SYS,
  input wire RESETN,
  // Host strobes and settings
  input wire IRQ_READ,
  input wire WD_EN_WR,
  input wire WD_EN_WDATA,
  input wire [3:0] BATTERY_OVERCURRENT_THRESHOLD,
  // Status and controls
  input wire CHARGER_IRQ,
  input wire CHARGER_OK_STATUS,
  input wire [3:0] CHARGER_DETAIL_FIELD,
  input wire THERMAL_REGULATION_STATUS,
  input wire [3:0] MODE_FIELD,
  input wire WATCHDOG_ENABLE_BIT,
  input wire CHARGE_ENABLE,
  input wire CONVERTER_ENABLE,
  input wire SHIP_MODE,
  input wire SERIAL_IF_ENABLE,
  input wire OVERCURRENT_MONITOR_EN,
  input wire [3:0] OVERCURRENT_THRESHOLD_OUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // Fresh entry into the fault code
  sequence s_enter_fault;
    CHARGER_DETAIL_FIELD == 4'h6 && $past(CHARGER_DETAIL_FIELD) != 4'h6;
  endsequence
  // Code held two cycles, so the one-cycle output lag has passed
  sequence s_held(logic [3:0] code);
    (CHARGER_DETAIL_FIELD == code)[*2];
  endsequence
  a_ok_from_detail: assert property (
    CHARGER_OK_STATUS == (CHARGER_DETAIL_FIELD <= 4'h4))
    else $error("ok bit disagrees with detail field");
  a_fault_irq: assert property (
    s_enter_fault |-> ##[0:2] CHARGER_IRQ)
    else $error("no irq on timer fault");
  a_fault_off: assert property (
    s_held(4'h6) |-> !CHARGE_ENABLE)
    else $error("charging during timer fault");
  a_wd_en_write: assert property (
    $rose(WATCHDOG_ENABLE_BIT) |-> $past(WD_EN_WR) && $past(WD_EN_WDATA))
    else $error("watchdog enabled without a write");
  a_wd_suspend: assert property (
    s_held(4'hB) |-> !CHARGE_ENABLE && CONVERTER_ENABLE)
    else $error("wrong power controls in watchdog suspend");
  a_shdn_reset: assert property (
    s_held(4'hA) |-> MODE_FIELD == 4'h5 && !WATCHDOG_ENABLE_BIT
      && !CHARGE_ENABLE)
    else $error("settings not defaulted in thermal shutdown");
  a_fold_irq: assert property (
    $changed(THERMAL_REGULATION_STATUS) |-> CHARGER_IRQ)
    else $error("foldback edge without irq");
  a_irq_sticky: assert property (
    CHARGER_IRQ && !IRQ_READ |=> CHARGER_IRQ)
    else $error("irq dropped without a read");
  a_ovc_follow: assert property (
    $stable(BATTERY_OVERCURRENT_THRESHOLD)[*4] |->
      OVERCURRENT_MONITOR_EN == (BATTERY_OVERCURRENT_THRESHOLD != 4'h0)
      && OVERCURRENT_THRESHOLD_OUT == BATTERY_OVERCURRENT_THRESHOLD)
    else $error("overcurrent monitor does not follow threshold");
  a_ship_serial: assert property (
    $stable(SHIP_MODE)[*2] |-> SERIAL_IF_ENABLE != SHIP_MODE)
    else $error("serial enable wrong for ship mode");
endmodule
bind css_supervisor css_supervisor_monitor css_supervisor_monitor_inst (.*);

// ---- dv/css_supervisor_tb_top.sv ----
// Self-checking bench for the charger safety supervisor
`timescale 1ns/1ns
module css_supervisor_tb_top;
  logic CLK_SYS = 0, RESETN = 0, INPUT_VALID = 0, STANDBY_PIN = 0;
  logic BATTERY_DISCONNECT_PIN = 0, DIE_OVER_SHDN = 0, DIE_OVER_REG = 0;
  logic BATT_COLD = 0, BATT_COOL = 0, BATT_WARM = 0, BATT_HOT = 0;
  logic VBAT_ABOVE_PRECHG = 0, VBAT_ABOVE_SYSMIN = 0, VBAT_AT_REG = 0;
  logic ICHG_BELOW_TOPOFF = 0, VBAT_BELOW_RESTART = 0, MODE_WR = 0;
  logic WD_EN_WR = 0, WD_EN_WDATA = 0, WD_CLR_WR, IRQ_READ = 0;
  logic CELLS_3S = 0, SHIP_MODE_BIT = 0, TEMP_ZONE_CONTROL_ENABLE = 1;
  logic [1:0] WD_CLR_WDATA, VOLTAGE_LOOP_OFFSET = 0;
  logic [1:0] CURRENT_LOOP_OFFSET = 0, CURRENT_SELECT;
  logic [3:0] MODE_WDATA = 0, BATTERY_OVERCURRENT_THRESHOLD = 0;
  logic [15:0] PREQUAL_TIME_LIMIT = 16'hFFFF, TOPOFF_DURATION = 16'hFFFF;
  logic [15:0] FAST_CHARGE_TIME_LIMIT = 16'hFFFF, WATCHDOG_PERIOD = 16'h14;
  logic [7:0] FAST_CHARGE_CURRENT_SETTING, COOL_CURRENT_SETTING;
  logic [7:0] TERMINATION_VOLTAGE_SETTING, COOL_VOLTAGE_SETTING;
  logic CHARGER_IRQ, CHARGER_OK_STATUS, THERMAL_REGULATION_STATUS;
  logic WATCHDOG_ENABLE_BIT, CHARGE_ENABLE, CONVERTER_ENABLE, TIMER_DOUBLED;
  logic SHIP_MODE, SERIAL_IF_ENABLE, OVERCURRENT_MONITOR_EN;
  logic [3:0] CHARGER_DETAIL_FIELD, MODE_FIELD, OVERCURRENT_THRESHOLD_OUT;
  logic [2:0] THERMISTOR_DETAIL_FIELD;
  logic [7:0] APPLIED_CURRENT, APPLIED_VOLTAGE;
  logic [10:0] CV_TRANSITION_OFFSET, CC_TRANSITION_OFFSET;
  logic svc = 0, bad_key = 0;
  int failures = 0, check_count = 0;
  // Short names keep the checks on one line
  wire [3:0] dtl = CHARGER_DETAIL_FIELD;
  wire irq = CHARGER_IRQ;
  wire ok = CHARGER_OK_STATUS;
  wire chg = CHARGE_ENABLE;
  // Small tick divisor so debounce and timers fit the run
  css_supervisor #(.TICK_CYCLES(4)) css_supervisor_inst (.*);
  css_host_model #(.GAP(40)) css_host_model_inst (.clk(CLK_SYS),
    .svc(svc), .bad_key(bad_key), .wr(WD_CLR_WR), .wdata(WD_CLR_WDATA));
  initial forever #2 CLK_SYS = ~CLK_SYS;
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Bounded wait for a detail code, then let outputs settle
  task automatic wait_dtl(input logic [3:0] d, input int n);
    for (int i = 0; i < n && dtl !== d; i++)
      cyc(1);
    chk(dtl === d, "detail code not reached");
    cyc(2);
  endtask
  // Gap after lowering avoids two writes in one time step
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(1);
  endtask
  function automatic logic [10:0] cv_ofs(input logic c3);
    return c3 ? 11'd344 : 11'd229;
  endfunction
  task automatic complete_run;
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the expected run length
  initial
  begin
    #200000;
    failures++;
    complete_run();
  end
  initial
  begin
    logic e;
    void'($urandom(32'h7ea3));
    FAST_CHARGE_CURRENT_SETTING = 8'h40 + 8'($urandom % 128);
    COOL_CURRENT_SETTING = FAST_CHARGE_CURRENT_SETTING >> 1;
    TERMINATION_VOLTAGE_SETTING = 8'h20 + 8'($urandom % 192);
    COOL_VOLTAGE_SETTING = 8'($urandom);
    CELLS_3S = 1'($urandom);
    cyc(2);
    chk(dtl === 4'h8 && MODE_FIELD === 4'h5 && ok === 1'b0, "reset");
    chk(WATCHDOG_ENABLE_BIT === 1'b0, "wd on at reset");
    chk(SERIAL_IF_ENABLE && THERMISTOR_DETAIL_FIELD === 3'h5, "rst");
    cyc(2);
    RESETN = 1;
    INPUT_VALID = 1;
    wait_dtl(4'h5, 400);
    chk(CURRENT_SELECT === 2'h0 && chg === 1'b1, "prechg sel");
    VBAT_ABOVE_PRECHG = 1;
    wait_dtl(4'h0, 400);
    chk(CURRENT_SELECT === 2'h1 && ok === 1'b1, "trickle sel");
    VOLTAGE_LOOP_OFFSET = 2'h1;
    CURRENT_LOOP_OFFSET = 2'h1;
    VBAT_ABOVE_SYSMIN = 1;
    wait_dtl(4'h1, 400);
    chk(CURRENT_SELECT === 2'h2, "fast sel");
    chk(CV_TRANSITION_OFFSET === cv_ofs(CELLS_3S), "cv ofs");
    chk(CC_TRANSITION_OFFSET === 11'd0, "cc ofs in loop");
    VOLTAGE_LOOP_OFFSET = 2'h0;
    cyc(4);
    chk(CV_TRANSITION_OFFSET === 11'd0, "cv ofs off");
    // Foldback edges both ways, ok untouched
    pulse(IRQ_READ);
    DIE_OVER_REG = 1;
    cyc(10);
    chk(THERMAL_REGULATION_STATUS === 1'b1 && irq === 1'b1, "fb");
    chk(ok === 1'b1, "fb ok");
    pulse(IRQ_READ);
    DIE_OVER_REG = 0;
    cyc(10);
    chk(THERMAL_REGULATION_STATUS === 1'b0 && irq === 1'b1, "fb");
    // Temperature zones; cool current is half the fast setting, rounded down
    BATT_WARM = 1;
    cyc(10);
    chk(THERMISTOR_DETAIL_FIELD === 3'h3, "warm zone");
    e = APPLIED_VOLTAGE === TERMINATION_VOLTAGE_SETTING - 8'h0C;
    chk(e, "warm v");
    BATT_WARM = 0;
    BATT_COOL = 1;
    cyc(10);
    chk(APPLIED_CURRENT === COOL_CURRENT_SETTING, "cool i");
    chk(APPLIED_VOLTAGE === COOL_VOLTAGE_SETTING, "cool v");
    chk(TIMER_DOUBLED === 1'b1, "half i timer");
    BATT_COOL = 0;
    BATT_HOT = 1;
    wait_dtl(4'hC, 200);
    chk(chg === 1'b0, "hot chg");
    BATT_HOT = 0;
    wait_dtl(4'h1, 400);
    chk(TIMER_DOUBLED === 1'b0, "full i timer");
    TEMP_ZONE_CONTROL_ENABLE = 0;
    BATT_COLD = 1;
    cyc(20);
    chk(THERMISTOR_DETAIL_FIELD === 3'h5 && dtl === 4'h1, "zone");
    BATT_COLD = 0;
    cyc(6);
    TEMP_ZONE_CONTROL_ENABLE = 1;
    // Watchdog serviced, then starved by a wrong key, then revived
    svc = 1;
    WD_EN_WDATA = 1;
    pulse(WD_EN_WR);
    chk(WATCHDOG_ENABLE_BIT === 1'b1, "wd en");
    cyc(600);
    chk(dtl === 4'h1, "wd fired while serviced");
    pulse(IRQ_READ);
    bad_key = 1;
    wait_dtl(4'hB, 300);
    chk(chg === 1'b0 && CONVERTER_ENABLE === 1'b1, "wd susp");
    chk(irq === 1'b1 && ok === 1'b0, "wd irq");
    bad_key = 0;
    wait_dtl(4'h1, 400);
    // Thermal shutdown with the watchdog still enabled
    pulse(IRQ_READ);
    DIE_OVER_SHDN = 1;
    wait_dtl(4'hA, 20);
    chk(irq === 1'b1 && WATCHDOG_ENABLE_BIT === 1'b0, "shdn");
    MODE_WDATA = 4'h0;
    pulse(MODE_WR);
    chk(MODE_FIELD === 4'h5 && chg === 1'b0, "shdn mode");
    DIE_OVER_SHDN = 0;
    svc = 0;
    wait_dtl(4'h1, 400);
    // Timer fault, left by mode off-on, by the pin, by replug
    for (int k = 0; k < 3; k++)
    begin
      pulse(IRQ_READ);
      FAST_CHARGE_TIME_LIMIT = 16'h0028;
      wait_dtl(4'h6, 800);
      chk(irq === 1'b1 && ok === 1'b0, "fault irq");
      FAST_CHARGE_TIME_LIMIT = 16'hFFFF;
      cyc(50);
      chk(dtl === 4'h6, "fault left early");
      MODE_WDATA = (k == 0) ? 4'h0 : 4'h5;
      pulse(MODE_WR);
      MODE_WDATA = 4'h5;
      BATTERY_DISCONNECT_PIN = (k == 1);
      INPUT_VALID = (k != 2);
      cyc(10);
      BATTERY_DISCONNECT_PIN = 0;
      INPUT_VALID = 1;
      pulse(MODE_WR);
      wait_dtl(4'h1, 400);
    end
    // Voltage loop, top-off, done
    VBAT_AT_REG = 1;
    wait_dtl(4'h2, 400);
    chk(CC_TRANSITION_OFFSET === 11'd625, "cc ofs");
    TOPOFF_DURATION = 16'h0028;
    ICHG_BELOW_TOPOFF = 1;
    wait_dtl(4'h3, 400);
    wait_dtl(4'h4, 400);
    // Ship mode on battery; writes refused until standby
    INPUT_VALID = 0;
    SHIP_MODE_BIT = 1;
    cyc(20);
    chk(SHIP_MODE === 1'b1 && SERIAL_IF_ENABLE === 1'b0, "ship");
    MODE_WDATA = 4'h0;
    pulse(MODE_WR);
    chk(MODE_FIELD === 4'h5, "write in ship");
    STANDBY_PIN = 1;
    cyc(20);
    chk(SHIP_MODE === 1'b0 && SERIAL_IF_ENABLE === 1'b1, "ship");
    SHIP_MODE_BIT = 0;
    STANDBY_PIN = 0;
    INPUT_VALID = 1;
    // Overcurrent threshold, zero first
    for (int k = 0; k < 8; k++)
    begin
      BATTERY_OVERCURRENT_THRESHOLD = (k == 0) ? 4'h0 : 4'($urandom);
      cyc(6);
      e = OVERCURRENT_MONITOR_EN === (BATTERY_OVERCURRENT_THRESHOLD != 0);
      e = e && OVERCURRENT_THRESHOLD_OUT === BATTERY_OVERCURRENT_THRESHOLD;
      chk(e, "ovc");
    end
    RESETN = 0;
    cyc(4);
    chk(dtl === 4'h8 && WATCHDOG_ENABLE_BIT === 1'b0, "reset 2");
    RESETN = 1;
    cyc(4);
    complete_run();
  end
endmodule
